// ---- rtl/wufpf_pkg.sv ----
package wufpf_pkg;
    localparam int          NUM_FILTERS   = 8;
    localparam int          NUM_WORDS     = 40;
    localparam int          MASK_WORDS    = 4;
    localparam int          MASK_BITS     = 128;
    localparam int          CMD_BASE      = 32;
    localparam int          OFS_BASE      = 34;
    localparam int          CRC_BASE      = 36;
    localparam int          PER_WORD4     = 4;
    localparam int          PER_WORD2     = 2;
    localparam int          PTR_W         = 6;
    localparam int          POS_W         = 9;
    localparam logic [5:0]  PTR_LAST      = 6'h27;
    localparam logic [5:0]  PTR_RESET     = 6'h00;
    localparam logic [9:0]  ADR_PORT      = 10'h000;
    localparam logic [9:0]  ADR_PTR       = 10'h004;
    localparam logic [9:0]  ADR_STATUS    = 10'h008;
    localparam int          CMD_EN_BIT    = 0;
    localparam int          CMD_ANY_BIT   = 2;
    localparam int          CMD_MC_BIT    = 3;
    localparam int          STAT_BUSY_BIT = 8;
    localparam logic [15:0] CRC_POLY      = 16'h8005;
    localparam logic [15:0] CRC_INIT      = 16'hFFFF;
    localparam logic [31:0] WORD_RESET    = 32'h00000000;
    localparam logic [8:0]  POS_MAX       = 9'h1FF;

    typedef enum logic [2:0] {
        WUFPF_IDLE  = 3'b001,
        WUFPF_RECV  = 3'b010,
        WUFPF_CHECK = 3'b100
    } wufpf_state_t;
endpackage

// ---- rtl/wufpf_crc16.sv ----
`timescale 1ns/100ps
`default_nettype none
module wufpf_crc16 (
    input  wire logic        clk_i,   // clock
    input  wire logic        rst_i,   // async reset, high
    input  wire logic        clr_i,   // restart at this byte
    input  wire logic        en_i,    // fold this byte in
    input  wire logic [7:0]  data_i,  // received byte
    output logic      [15:0] crc_o    // running crc
);
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c;
        for (int b = 7; b >= 0; b--) begin
            if (x[15] ^ d[b]) begin
                x = {x[14:0], 1'b0} ^ wufpf_pkg::CRC_POLY;
            end else begin
                x = {x[14:0], 1'b0};
            end
        end
        return x;
    endfunction

    always_comb begin
        logic [15:0] base;
        base = clr_i ? wufpf_pkg::CRC_INIT : crc_r;
        crc_nxt = en_i ? step(base, data_i) : base;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            crc_r <= wufpf_pkg::CRC_INIT;
        end else begin
            crc_r <= crc_nxt;
        end
    end

    assign crc_o = crc_r;
endmodule // wufpf_crc16
`default_nettype wire

// ---- rtl/wufpf_top.sv ----
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module wufpf_top (
    input  wire logic        clk_i,        // 25 MHz clock
    input  wire logic        rst_i,        // async reset, high
    input  wire logic        wb_cyc_i,     // wishbone cycle
    input  wire logic        wb_stb_i,     // wishbone strobe
    input  wire logic        wb_we_i,      // wishbone write
    input  wire logic [9:0]  wb_adr_i,     // byte address
    input  wire logic [3:0]  wb_sel_i,     // byte enables
    input  wire logic [31:0] wb_dat_i,     // write data
    output logic      [31:0] wb_dat_o,     // read data
    output logic             wb_ack_o,     // acknowledge
    input  wire logic        rx_valid_i,   // byte strobe
    input  wire logic [7:0]  rx_data_i,    // received byte
    input  wire logic        rx_sof_i,     // first destination byte
    input  wire logic        rx_eof_i,     // last byte of frame
    input  wire logic        rx_unicast_i, // frame is unicast
    input  wire logic        rx_mcast_i,   // frame is multicast
    input  wire logic        rx_pass_i,    // passed regular filter
    output logic      [7:0]  match_o,      // per filter match, pulse
    output logic             wake_o        // any filter matched, pulse
);
    localparam int NF = wufpf_pkg::NUM_FILTERS;

    logic [31:0] mem_r   [wufpf_pkg::NUM_WORDS];
    logic [31:0] mem_nxt [wufpf_pkg::NUM_WORDS];
    logic [5:0]  ptr_r, ptr_nxt;
    logic        ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;

    wufpf_pkg::wufpf_state_t st_r, st_nxt;
    logic [8:0]  pos_r, pos_nxt;
    logic [7:0]  match_r, match_nxt;
    logic        wake_r, wake_nxt;
    logic [7:0]  last_r, last_nxt;
    logic        uc_r, uc_nxt, mc_r, mc_nxt, pass_r, pass_nxt;

    logic [8:0]  cur_pos;
    logic [7:0]  take;
    logic [15:0] crc [NF];
    logic [7:0]  hit;
    logic        req;

    assign req     = wb_cyc_i & wb_stb_i & ~ack_r;
    assign cur_pos = rx_sof_i ? 9'h000 : pos_r;

    // bus: port access walks a pointer through the structure
    always_comb begin
        for (int k = 0; k < wufpf_pkg::NUM_WORDS; k++) begin
            mem_nxt[k] = mem_r[k];
        end
        ptr_nxt  = ptr_r;
        ack_nxt  = req;
        rdat_nxt = rdat_r;
        if (req) begin
            rdat_nxt = wufpf_pkg::WORD_RESET;
            case (wb_adr_i)
                wufpf_pkg::ADR_PORT: begin
                    if (wb_we_i) begin
                        for (int b = 0; b < 4; b++) begin
                            if (wb_sel_i[b]) begin
                                mem_nxt[ptr_r][b*8 +: 8] = wb_dat_i[b*8 +: 8];
                            end
                        end
                    end else begin
                        rdat_nxt = mem_r[ptr_r];
                    end
                    ptr_nxt = (ptr_r == wufpf_pkg::PTR_LAST) ? wufpf_pkg::PTR_RESET : ptr_r + 6'h01;
                end
                wufpf_pkg::ADR_PTR: begin
                    if (wb_we_i) begin
                        if (wb_sel_i[0]) begin
                            ptr_nxt = (wb_dat_i[5:0] > wufpf_pkg::PTR_LAST) ? wufpf_pkg::PTR_RESET
                                                                             : wb_dat_i[5:0];
                        end
                    end else begin
                        rdat_nxt = {26'h0000000, ptr_r};
                    end
                end
                wufpf_pkg::ADR_STATUS: begin
                    if (!wb_we_i) begin
                        rdat_nxt = {23'h000000, (st_r != wufpf_pkg::WUFPF_IDLE), last_r};
                    end
                end
                default: begin
                    rdat_nxt = wufpf_pkg::WORD_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int k = 0; k < wufpf_pkg::NUM_WORDS; k++) begin
                mem_r[k] <= wufpf_pkg::WORD_RESET;
            end
            ptr_r  <= wufpf_pkg::PTR_RESET;
            ack_r  <= 1'b0;
            rdat_r <= wufpf_pkg::WORD_RESET;
        end else begin
            for (int k = 0; k < wufpf_pkg::NUM_WORDS; k++) begin
                mem_r[k] <= mem_nxt[k];
            end
            ptr_r  <= ptr_nxt;
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    genvar f;
    generate
        for (f = 0; f < NF; f++) begin : g_flt
            logic [127:0] mask;
            logic [7:0]   cmd;
            logic [7:0]   ofs;
            logic [15:0]  val;
            logic [8:0]   rel;
            logic         addr_ok;

            assign mask = {mem_r[f*wufpf_pkg::MASK_WORDS + 3], mem_r[f*wufpf_pkg::MASK_WORDS + 2],
                           mem_r[f*wufpf_pkg::MASK_WORDS + 1], mem_r[f*wufpf_pkg::MASK_WORDS]};
            assign cmd  = mem_r[wufpf_pkg::CMD_BASE + f/wufpf_pkg::PER_WORD4][(f%4)*8 +: 8];
            assign ofs  = mem_r[wufpf_pkg::OFS_BASE + f/wufpf_pkg::PER_WORD4][(f%4)*8 +: 8];
            assign val  = mem_r[wufpf_pkg::CRC_BASE + f/wufpf_pkg::PER_WORD2][(f%2)*16 +: 16];
            assign rel  = cur_pos - {1'b0, ofs};
            // lsb of each word is the earliest byte of its span
            assign take[f] = (cur_pos >= {1'b0, ofs}) && (rel < 9'h080) && mask[rel[6:0]];

            // address type: x1 any passed, 10 multicast, 00 unicast
            assign addr_ok = cmd[wufpf_pkg::CMD_ANY_BIT] ? pass_r
                           : (cmd[wufpf_pkg::CMD_MC_BIT] ? (pass_r & mc_r) : (pass_r & uc_r));
            assign hit[f]  = cmd[wufpf_pkg::CMD_EN_BIT] & addr_ok & (crc[f] == val);

            wufpf_crc16 u_crc (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .clr_i  (rx_valid_i & rx_sof_i),
                .en_i   (rx_valid_i & take[f] & (rx_sof_i | (st_r == wufpf_pkg::WUFPF_RECV))),
                .data_i (rx_data_i),
                .crc_o  (crc[f])
            );
        end
    endgenerate

    // receive: count bytes from destination start, check at frame end
    always_comb begin
        st_nxt    = st_r;
        pos_nxt   = pos_r;
        match_nxt = 8'h00;
        wake_nxt  = 1'b0;
        last_nxt  = last_r;
        uc_nxt    = uc_r;
        mc_nxt    = mc_r;
        pass_nxt  = pass_r;
        case (st_r)
            wufpf_pkg::WUFPF_IDLE, wufpf_pkg::WUFPF_RECV: begin
                if (rx_valid_i && (rx_sof_i || st_r == wufpf_pkg::WUFPF_RECV)) begin
                    pos_nxt = (cur_pos == wufpf_pkg::POS_MAX) ? cur_pos : cur_pos + 9'h001;
                    st_nxt  = wufpf_pkg::WUFPF_RECV;
                    if (rx_eof_i) begin
                        uc_nxt   = rx_unicast_i;
                        mc_nxt   = rx_mcast_i;
                        pass_nxt = rx_pass_i;
                        st_nxt   = wufpf_pkg::WUFPF_CHECK;
                    end
                end
            end
            wufpf_pkg::WUFPF_CHECK: begin
                match_nxt = hit;
                wake_nxt  = |hit;
                last_nxt  = hit;
                st_nxt    = wufpf_pkg::WUFPF_IDLE;
                pos_nxt   = 9'h000;
                // next frame may start while this one is judged
                if (rx_valid_i && rx_sof_i) begin
                    pos_nxt = 9'h001;
                    st_nxt  = wufpf_pkg::WUFPF_RECV;
                    if (rx_eof_i) begin
                        uc_nxt   = rx_unicast_i;
                        mc_nxt   = rx_mcast_i;
                        pass_nxt = rx_pass_i;
                        st_nxt   = wufpf_pkg::WUFPF_CHECK;
                    end
                end
            end
            default: begin
                st_nxt = wufpf_pkg::WUFPF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r    <= wufpf_pkg::WUFPF_IDLE;
            pos_r   <= 9'h000;
            match_r <= 8'h00;
            wake_r  <= 1'b0;
            last_r  <= 8'h00;
            uc_r    <= 1'b0;
            mc_r    <= 1'b0;
            pass_r  <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            pos_r   <= pos_nxt;
            match_r <= match_nxt;
            wake_r  <= wake_nxt;
            last_r  <= last_nxt;
            uc_r    <= uc_nxt;
            mc_r    <= mc_nxt;
            pass_r  <= pass_nxt;
        end
    end

    assign wb_dat_o = rdat_r;
    assign wb_ack_o = ack_r;
    assign match_o  = match_r;
    assign wake_o   = wake_r;
endmodule // wufpf_top
`default_nettype wire

// ---- dv/wufpf_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module wufpf_monitor (
    input  wire logic        clk_i,      // clock
    input  wire logic        rst_i,      // async reset, high
    input  wire logic        wb_cyc_i,   // wishbone cycle
    input  wire logic        wb_stb_i,   // wishbone strobe
    input  wire logic        wb_we_i,    // wishbone write
    input  wire logic [9:0]  wb_adr_i,   // byte address
    input  wire logic [31:0] wb_dat_o,   // read data
    input  wire logic        wb_ack_o,   // acknowledge
    input  wire logic        rx_valid_i, // byte strobe
    input  wire logic        rx_eof_i,   // last byte
    input  wire logic        rx_pass_i,  // passed regular filter
    input  wire logic [7:0]  match_o,    // per filter match
    input  wire logic        wake_o      // any match
);
    wire req = wb_cyc_i & wb_stb_i;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_answer_a: assert property ($rose(req) |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    ptr_range_a: assert property ($rose(req) && !wb_we_i && wb_adr_i == wufpf_pkg::ADR_PTR
        |=> wb_dat_o[5:0] <= wufpf_pkg::PTR_LAST) else $error("pointer beyond last word");
    wake_or_a: assert property (wake_o == (|match_o))
        else $error("wake differs from or of matches");
    match_pulse_a: assert property ((|match_o) |=> match_o == 8'h00)
        else $error("match longer than one cycle");
    match_eof_a: assert property ((|match_o) |-> $past(rx_valid_i & rx_eof_i, 2))
        else $error("match not two cycles after frame end");
    match_pass_a: assert property ((|match_o) |-> $past(rx_pass_i, 2))
        else $error("match on frame that failed regular filter");

    cover property (wake_o);
    cover property (match_o[1]);
    cover property ($rose(req) && !wb_we_i);
endmodule // wufpf_monitor
bind wufpf_top wufpf_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_valid_i(rx_valid_i), .rx_eof_i(rx_eof_i), .rx_pass_i(rx_pass_i), .match_o(match_o), .wake_o(wake_o));
`default_nettype wire

// ---- dv/wufpf_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module wufpf_host (
    input  wire logic        clk_i, // clock
    input  wire logic        ack_i, // slave ack
    input  wire logic [31:0] dat_i, // read data
    output logic             cyc_o, // cyc and stb
    output logic             we_o,  // write
    output logic      [9:0]  adr_o, // byte address
    output logic      [31:0] dat_o  // write data
);
    initial {cyc_o, we_o, adr_o, dat_o} = '0;

    // one classic cycle, held until ack sampled high
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        dat_o <= d;
        do @(posedge clk_i);
        while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
    endtask
endmodule // wufpf_host
`default_nettype wire

// ---- dv/wufpf_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module wufpf_top_tb;
    logic        clk_i, rst_i, cyc, we, ack, rxv, sof, eof, uc, mc, ps, wake;
    logic [9:0]  adr;
    logic [31:0] wd, rd, q;
    logic [7:0]  rxd, match, xm;
    logic [7:0]  fr[48];
    logic [31:0] mem[40];
    logic [7:0]  cmd[8] = '{8'h01, 8'h09, 8'h05, 8'h0D, 8'h00, 8'h01, 8'h09, 8'h05};
    int          err_total = 0;
    int          checks = 0;
    int          seed = 64;

    wufpf_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(wd));
    wufpf_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
        .rx_valid_i(rxv), .rx_data_i(rxd), .rx_sof_i(sof), .rx_eof_i(eof), .rx_unicast_i(uc),
        .rx_mcast_i(mc), .rx_pass_i(ps), .match_o(match), .wake_o(wake));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (err_total == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // msb-first crc over masked bytes from the offset on
    function automatic logic [15:0] crc_of(input int f);
        logic [15:0] c;
        int          j;
        c = wufpf_pkg::CRC_INIT;
        for (int p = 0; p < 48; p++) begin
            j = p - int'(mem[34 + f / 4][8 * (f % 4) +: 8]);
            if (j >= 0 && j < 128 && mem[4 * f + j / 32][j % 32])
                for (int b = 7; b >= 0; b--)
                    c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[p][b]) ? wufpf_pkg::CRC_POLY : 16'h0000);
        end
        return c;
    endfunction

    task automatic send(input logic u, input logic m, input logic p);
        for (int i = 0; i < 48; i++) begin
            @(posedge clk_i);
            rxv <= 1'b1;
            rxd <= fr[i];
            sof <= (i == 0);
            eof <= (i == 47);
            {uc, mc, ps} <= {u, m, p};
        end
        @(posedge clk_i);
        {rxv, eof} <= 2'b00;
        for (int f = 0; f < 8; f++) xm[f] = cmd[f][0] && f != 7 && p && (cmd[f][2] || (cmd[f][3] ? m : u));
        @(posedge clk_i);
        #1;
        chk(32'(match), 32'(xm));
        chk(32'(wake), 32'(|xm));
        host.xfer(1'b0, wufpf_pkg::ADR_STATUS, 32'h0, q);
        chk(32'(q[7:0]), 32'(xm));
    endtask

    initial begin
        {rxv, sof, eof, uc, mc, ps} = '0;
        rxd = 8'h00;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        host.xfer(1'b0, wufpf_pkg::ADR_PORT, 32'h0, q);
        chk(q, wufpf_pkg::WORD_RESET);
        host.xfer(1'b1, wufpf_pkg::ADR_PTR, 32'h3F, q);
        host.xfer(1'b0, wufpf_pkg::ADR_PTR, 32'h0, q);
        chk(q, 32'h0);
        host.xfer(1'b0, 10'h00C, 32'h0, q);
        chk(q, 32'h0);
        for (int i = 0; i < 48; i++) fr[i] = 8'($random(seed));
        for (int k = 0; k < 40; k++) mem[k] = (k < 32) ? $random(seed) : 32'h0;
        for (int f = 0; f < 8; f++) begin
            mem[32 + f / 4][8 * (f % 4) +: 8] = cmd[f];
            mem[34 + f / 4][8 * (f % 4) +: 8] = 8'($random(seed)) & 8'h07;
        end
        for (int f = 0; f < 8; f++) mem[36 + f / 2][16 * (f % 2) +: 16] = crc_of(f) ^ 16'(f == 7);
        for (int k = 0; k < 40; k++) host.xfer(1'b1, wufpf_pkg::ADR_PORT, mem[k], q);
        for (int k = 0; k < 40; k++) begin
            host.xfer(1'b0, wufpf_pkg::ADR_PORT, 32'h0, q);
            chk(q, mem[k]);
        end
        for (int c = 0; c < 4; c++) send(c == 0 || c == 3, c == 1, c != 3);
        host.xfer(1'b1, wufpf_pkg::ADR_PTR, 32'h5, q);
        host.xfer(1'b0, wufpf_pkg::ADR_PTR, 32'h0, q);
        chk(q, 32'h5);
        host.xfer(1'b0, wufpf_pkg::ADR_PORT, 32'h0, q);
        chk(q, mem[5]);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        host.xfer(1'b0, wufpf_pkg::ADR_PTR, 32'h0, q);
        chk(q, 32'h0);
        host.xfer(1'b0, wufpf_pkg::ADR_PORT, 32'h0, q);
        chk(q, wufpf_pkg::WORD_RESET);
        complete_run();
    end

    initial begin
        #800000;
        err_total++;
        complete_run();
    end
endmodule // wufpf_top_tb
`default_nettype wire
